// ==== pkg/lpm_params.svh ====
// lpm_params.svh: signature bytes, field positions, reset values and timing counts
// assumes: included by bare name from the lpm module and its testbench
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH
// -----------------------------------------------------------------------
// signature bytes and planning register layout
// -----------------------------------------------------------------------
`define LPM_SIG_FIRST       8'h57
`define LPM_SIG_SECOND      8'ha8
`define LPM_PLAN_W          16
`define LPM_PLAN_RESET      16'h009f
`define LPM_BIT_SYS_KEEP    7
`define LPM_BIT_LARGE_RAM   4
`define LPM_BIT_EXTEND      3
`define LPM_BIT_CORE        2
`define LPM_BIT_SMALL_RAM   1
`define LPM_BIT_CLK32K      0
`define LPM_BIT_DCDC_EN     15
`define LPM_BIT_DCDC_PRE    14
// -----------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------
`define LPM_CLK_MHZ         20
`define LPM_SAFE_WIN_CYC    16
`define LPM_STEP_CYC        4
`endif

// ==== pkg/lpm_pkg.sv ====
// lpm_pkg.sv: types of the low-power sequencer
// assumes: constants come from lpm_params.svh
package lpm_pkg;
   // gray codes along run -> stop -> (clocks/regulator) -> wake
   typedef enum logic [3:0] {
      LPM_RUN      = 4'b0000,
      LPM_IDLE     = 4'b0001,
      LPM_HALT     = 4'b0011,
      LPM_SLEEP    = 4'b0010,
      LPM_SHUT     = 4'b0110,
      LPM_WAKE_REG = 4'b0111,
      LPM_WAKE_CLK = 4'b0101,
      LPM_RESET    = 4'b0100
   } lpm_state_t;
endpackage

// ==== rtl/lpm_seq.sv ====
// lpm_seq.sv: low-power mode sequencer with dc-dc safe-access control
// assumes: core signals and write strobes on clk_sys_i; wake pins async
//
// Function
// - after reset, run state, core executing
// - idle: core stopped, clocks on, instant resume
// - halt stops clocks; wake restarts clocks first
// - sleep: main regulator off, low-power keeps core
// - sleep wake: regulator, then clocks, then core
// - shutdown also powers off core and extend
// - shutdown wake issues global reset, flagged
// - protected writes need both signature bytes
// - clearing both dc-dc bits gives pass-through
// - plan bits apply only in sleep, shutdown; dc-dc bits at once
`timescale 1ns/1ps
`include "lpm_params.svh"
module lpm_seq (
   input  wire logic                   clk_sys_i,
   input  wire logic                   resetn_i,
   input  wire logic                   clk_en_i,
   input  wire logic                   core_wait_i,
   input  wire logic                   core_sleep_control_i,
   input  wire logic [3:0]             wake_pins_i,
   input  wire logic                   sig_wr_i,
   input  wire logic [7:0]             sig_data_i,
   input  wire logic                   plan_wr_i,
   input  wire logic [`LPM_PLAN_W-1:0] plan_data_i,
   output logic                        core_run_o,
   output logic                        clocks_on_o,
   output logic                        main_reg_on_o,
   output logic                        ulp_reg_on_o,
   output logic                        core_pwr_o,
   output logic                        extend_pwr_o,
   output logic                        small_ram_pwr_o,
   output logic                        large_ram_pwr_o,
   output logic                        low_speed_clock_o,
   output logic                        system_supply_keep_o,
   output logic                        global_wake_reset_o,
   output logic                        reset_cause_flag_o,
   output logic                        safe_open_o,
   output logic [`LPM_PLAN_W-1:0]      power_planning_reg_o,
   output logic                        dcdc_bias_o,
   output logic                        dcdc_on_o
);
   // -----------------------------------------------------------------------
   // wake pin synchroniser
   // -----------------------------------------------------------------------
   logic [3:0] wake_s1;
   logic [3:0] wake_s2;
   logic       wake_any;
   // first stage is read only by the second stage
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wake_s1 <= 4'h0;
         wake_s2 <= 4'h0;
      end else if (clk_en_i) begin
         wake_s1 <= wake_pins_i;
         wake_s2 <= wake_s1;
      end
   end
   assign wake_any = |wake_s2;

   // -----------------------------------------------------------------------
   // safe access and power planning register
   // -----------------------------------------------------------------------
   logic                   armed;
   logic [4:0]             win_cnt;
   logic [`LPM_PLAN_W-1:0] plan;
   logic                   next_armed;
   logic [4:0]             next_win_cnt;
   logic [`LPM_PLAN_W-1:0] next_plan;
   // a stray byte between the two signature bytes disarms the sequence
   always_comb begin
      next_armed   = armed;
      next_win_cnt = win_cnt;
      next_plan    = plan;
      if (win_cnt != 5'h00)
         next_win_cnt = win_cnt - 5'h01;
      if (plan_wr_i && win_cnt != 5'h00) begin
         next_plan    = plan_data_i;
         next_win_cnt = 5'h00;                           // one write per open
      end
      // a reopen in the cycle of the closing write wins over the close
      if (sig_wr_i) begin
         if (armed && sig_data_i == `LPM_SIG_SECOND) begin
            next_armed   = 1'b0;
            next_win_cnt = 5'(`LPM_SAFE_WIN_CYC);
         end else begin
            next_armed = (sig_data_i == `LPM_SIG_FIRST);
         end
      end
   end
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         armed   <= 1'b0;
         win_cnt <= 5'h00;
         plan    <= `LPM_PLAN_RESET;
      end else if (clk_en_i) begin
         armed   <= next_armed;
         win_cnt <= next_win_cnt;
         plan    <= next_plan;
      end
   end
   assign safe_open_o          = (win_cnt != 5'h00);
   assign power_planning_reg_o = plan;
   // dc-dc bits act at once; both low means pass-through
   assign dcdc_bias_o = plan[`LPM_BIT_DCDC_PRE];
   assign dcdc_on_o   = plan[`LPM_BIT_DCDC_EN] &
                        plan[`LPM_BIT_DCDC_PRE];

   // -----------------------------------------------------------------------
   // mode sequencer
   // -----------------------------------------------------------------------
   lpm_pkg::lpm_state_t state;
   lpm_pkg::lpm_state_t next_state;
   logic [2:0]          step;
   logic [2:0]          next_step;
   logic                cause;
   logic                next_cause;
   logic                deep_plan;
   logic                core_keep;
   assign deep_plan = ~plan[`LPM_BIT_SYS_KEEP];
   assign core_keep = plan[`LPM_BIT_CORE];
   // the wake steps use a fixed settle count, not a regulator ready input
   always_comb begin
      next_state = state;
      next_step  = step;
      next_cause = cause;
      if (step != 3'h0)
         next_step = step - 3'h1;
      unique case (state)
         lpm_pkg::LPM_RUN: begin
            if (core_wait_i) begin
               if (!core_sleep_control_i)
                  next_state = lpm_pkg::LPM_IDLE;
               else if (!deep_plan)
                  next_state = lpm_pkg::LPM_HALT;
               else if (core_keep)
                  next_state = lpm_pkg::LPM_SLEEP;
               else
                  next_state = lpm_pkg::LPM_SHUT;
            end
         end
         lpm_pkg::LPM_IDLE:
            if (wake_any)
               next_state = lpm_pkg::LPM_RUN;
         lpm_pkg::LPM_HALT:
            if (wake_any) begin
               next_state = lpm_pkg::LPM_WAKE_CLK;
               next_step  = 3'(`LPM_STEP_CYC);
            end
         lpm_pkg::LPM_SLEEP:
            if (wake_any) begin
               next_state = lpm_pkg::LPM_WAKE_REG;
               next_step  = 3'(`LPM_STEP_CYC);
            end
         lpm_pkg::LPM_SHUT:
            if (wake_any) begin
               next_state = lpm_pkg::LPM_RESET;
               next_step  = 3'(`LPM_STEP_CYC);
               next_cause = 1'b1;
            end
         lpm_pkg::LPM_WAKE_REG:
            if (step == 3'h0) begin
               next_state = lpm_pkg::LPM_WAKE_CLK;
               next_step  = 3'(`LPM_STEP_CYC);
            end
         lpm_pkg::LPM_WAKE_CLK:
            if (step == 3'h0)
               next_state = lpm_pkg::LPM_RUN;
         lpm_pkg::LPM_RESET:
            if (step == 3'h0)
               next_state = lpm_pkg::LPM_RUN;
         default: next_state = lpm_pkg::LPM_RUN;
      endcase
   end
   // the cause flag survives the global reset it reports
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= lpm_pkg::LPM_RUN;
         step  <= 3'h0;
         cause <= 1'b0;
      end else if (clk_en_i) begin
         state <= next_state;
         step  <= next_step;
         cause <= next_cause;
      end
   end

   // -----------------------------------------------------------------------
   // power and clock outputs
   // -----------------------------------------------------------------------
   logic low_pwr;
   logic is_shut;
   assign low_pwr = (state == lpm_pkg::LPM_SLEEP) ||
                    (state == lpm_pkg::LPM_SHUT);
   assign is_shut = (state == lpm_pkg::LPM_SHUT) ||
                    (state == lpm_pkg::LPM_RESET);
   assign core_run_o    = (state == lpm_pkg::LPM_RUN);
   // clocks run again during the restart step, before the core is let go
   assign clocks_on_o   = (state == lpm_pkg::LPM_RUN) ||
                          (state == lpm_pkg::LPM_IDLE) ||
                          (state == lpm_pkg::LPM_WAKE_CLK);
   assign main_reg_on_o = !low_pwr && !is_shut;
   assign ulp_reg_on_o  = 1'b1;
   assign core_pwr_o    = !is_shut;
   assign extend_pwr_o  = is_shut ? 1'b0 :
                          (low_pwr ? plan[`LPM_BIT_EXTEND] : 1'b1);
   assign small_ram_pwr_o = low_pwr ? plan[`LPM_BIT_SMALL_RAM] : 1'b1;
   assign large_ram_pwr_o = low_pwr ? plan[`LPM_BIT_LARGE_RAM] : 1'b1;
   assign low_speed_clock_o = low_pwr ? plan[`LPM_BIT_CLK32K] : 1'b1;
   assign system_supply_keep_o = !low_pwr;
   assign global_wake_reset_o  = (state == lpm_pkg::LPM_RESET);
   assign reset_cause_flag_o   = cause;

   // -----------------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------------
   property p_idle_wake;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (clk_en_i && state == lpm_pkg::LPM_IDLE && wake_any) |=> core_run_o;
   endproperty
   a_idle_wake: assert property (p_idle_wake)
      else $error("idle did not resume at once");
   property p_sleep_order;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (state == lpm_pkg::LPM_WAKE_CLK &&
       $past(state) == lpm_pkg::LPM_WAKE_REG)
      |-> $past(main_reg_on_o) && clocks_on_o && !core_run_o;
   endproperty
   a_sleep_order: assert property (p_sleep_order)
      else $error("clocks restarted before regulator");
   property p_wake_clk_first;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      $rose(core_run_o) && $past(state) == lpm_pkg::LPM_WAKE_CLK
      |-> $past(clocks_on_o);
   endproperty
   a_wake_clk_first: assert property (p_wake_clk_first)
      else $error("core released before clocks");
   property p_shut_pwr;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      state == lpm_pkg::LPM_SHUT |-> !core_pwr_o && !extend_pwr_o;
   endproperty
   a_shut_pwr: assert property (p_shut_pwr)
      else $error("core powered in shutdown");
   property p_shut_reset;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (clk_en_i && state == lpm_pkg::LPM_SHUT && wake_any)
      |=> global_wake_reset_o && reset_cause_flag_o;
   endproperty
   a_shut_reset: assert property (p_shut_reset)
      else $error("shutdown wake gave no reset");
   property p_sig_open;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (clk_en_i && sig_wr_i && armed && sig_data_i == `LPM_SIG_SECOND)
      |=> safe_open_o;
   endproperty
   a_sig_open: assert property (p_sig_open)
      else $error("signature did not open access");
   property p_locked;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (plan_wr_i && !safe_open_o) |=> $stable(power_planning_reg_o);
   endproperty
   a_locked: assert property (p_locked)
      else $error("plan changed while locked");
   property p_run_plan;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      core_run_o |-> system_supply_keep_o && small_ram_pwr_o
      && large_ram_pwr_o;
   endproperty
   a_run_plan: assert property (p_run_plan)
      else $error("plan applied during run");
   c_idle: cover property (@(posedge clk_sys_i)
      state == lpm_pkg::LPM_IDLE ##1 core_run_o);
   c_sleep: cover property (@(posedge clk_sys_i)
      state == lpm_pkg::LPM_WAKE_REG);
   c_shut: cover property (@(posedge clk_sys_i) global_wake_reset_o);
   c_dcdc: cover property (@(posedge clk_sys_i) dcdc_on_o);
endmodule // lpm_seq

// ==== test/test_lpm_seq.sv ====
// test_lpm_seq.sv: self-checking bench for the low-power sequencer
// assumes: lpm_params.svh on the include path, lpm_seq compiled before
`timescale 1ns/1ps
`include "lpm_params.svh"
module test_lpm_seq;
   logic        clk_sys_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic        clk_en_i = 1'b1;
   logic        core_wait_i = 1'b0;
   logic        core_sleep_control_i = 1'b0;
   logic [3:0]  wake_pins_i = 4'h0;
   logic        sig_wr_i = 1'b0;
   logic [7:0]  sig_data_i = 8'h00;
   logic        plan_wr_i = 1'b0;
   logic [15:0] plan_data_i = 16'h0000;
   logic        core_run_o, clocks_on_o, main_reg_on_o, ulp_reg_on_o;
   logic        core_pwr_o, extend_pwr_o, small_ram_pwr_o, large_ram_pwr_o;
   logic        low_speed_clock_o, system_supply_keep_o, global_wake_reset_o;
   logic        reset_cause_flag_o, safe_open_o, dcdc_bias_o, dcdc_on_o;
   logic [15:0] power_planning_reg_o;
   int          error_cnt = 0;
   int          comparisons = 0;
   int          seed = 30755;
   int          lat_i, lat_h, lat, regfirst, clkfirst;
   logic        saw_rst;
   logic [15:0] p;

   lpm_seq u_lpm_seq (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .clk_en_i(clk_en_i), .core_wait_i(core_wait_i),
      .core_sleep_control_i(core_sleep_control_i), .wake_pins_i(wake_pins_i),
      .sig_wr_i(sig_wr_i), .sig_data_i(sig_data_i), .plan_wr_i(plan_wr_i),
      .plan_data_i(plan_data_i), .core_run_o(core_run_o),
      .clocks_on_o(clocks_on_o), .main_reg_on_o(main_reg_on_o),
      .ulp_reg_on_o(ulp_reg_on_o), .core_pwr_o(core_pwr_o),
      .extend_pwr_o(extend_pwr_o), .small_ram_pwr_o(small_ram_pwr_o),
      .large_ram_pwr_o(large_ram_pwr_o), .low_speed_clock_o(low_speed_clock_o),
      .system_supply_keep_o(system_supply_keep_o),
      .global_wake_reset_o(global_wake_reset_o),
      .reset_cause_flag_o(reset_cause_flag_o), .safe_open_o(safe_open_o),
      .power_planning_reg_o(power_planning_reg_o), .dcdc_bias_o(dcdc_bias_o),
      .dcdc_on_o(dcdc_on_o));

   // ----------------------------------------------------------------
   // clock, watchdog and verdict
   // ----------------------------------------------------------------
   always #25 clk_sys_i = ~clk_sys_i;

   // whole run is a few hundred cycles; 20000 leaves ample margin
   initial begin
      #(50 * 20000);
      error_cnt++;
      close_out();
   end

   task automatic close_out();
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // compare, expectation and stimulus helpers
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // m: 0 run, 1 idle, 2 halt, 3 sleep, 4 shutdown
   function automatic logic [15:0] exp_outs(input int m, input logic [15:0] q);
      case (m)
         1: exp_outs = 16'h01ff;
         2: exp_outs = 16'h00ff;
         3: exp_outs = {9'h000, 1'b1, 1'b1, q[3], q[1], q[4], q[0], 1'b0};
         4: exp_outs = {9'h000, 1'b1, 1'b0, 1'b0, q[1], q[4], q[0], 1'b0};
         default: exp_outs = 16'h03ff;
      endcase
   endfunction

   function automatic logic [15:0] outs();
      outs = {6'h00, core_run_o, clocks_on_o, main_reg_on_o, ulp_reg_on_o,
              core_pwr_o, extend_pwr_o, small_ram_pwr_o, large_ram_pwr_o,
              low_speed_clock_o, system_supply_keep_o};
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic sig(input logic [7:0] b);
      @(posedge clk_sys_i);
      sig_wr_i   <= 1'b1;
      sig_data_i <= b;
      @(posedge clk_sys_i);
      sig_wr_i   <= 1'b0;
      #1;
   endtask

   task automatic open_safe();
      sig(`LPM_SIG_FIRST);
      sig(`LPM_SIG_SECOND);
   endtask

   task automatic plan_wr(input logic [15:0] v);
      @(posedge clk_sys_i);
      plan_wr_i   <= 1'b1;
      plan_data_i <= v;
      @(posedge clk_sys_i);
      plan_wr_i   <= 1'b0;
      #1;
   endtask

   task automatic enter(input logic deep);
      @(posedge clk_sys_i);
      core_sleep_control_i <= deep;
      core_wait_i          <= 1'b1;
      @(posedge clk_sys_i);
      core_wait_i          <= 1'b0;
      tick(2);
   endtask

   // raises one random wake source and measures how long the core waits
   task automatic wake(output int l, output logic rst, output int rf,
                       output int cf);
      int k;
      k = $unsigned($random(seed)) % 4;
      @(posedge clk_sys_i);
      wake_pins_i <= 4'h1 << k;
      l   = 0;
      rst = 1'b0;
      rf  = -1;
      cf  = -1;
      while (core_run_o !== 1'b1 && l < 60) begin
         tick(1);
         l++;
         if (global_wake_reset_o === 1'b1) rst = 1'b1;
         if (main_reg_on_o === 1'b1 && rf < 0) rf = l;
         if (clocks_on_o === 1'b1 && cf < 0) cf = l;
      end
      @(posedge clk_sys_i);
      wake_pins_i <= 4'h0;
      chk("woke", 16'h0001, {15'h0, core_run_o});
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      tick(3);
      chk("rst_outs", exp_outs(0, 16'h0), outs());
      chk("rst_plan", `LPM_PLAN_RESET, power_planning_reg_o);
      chk("rst_flags", 16'h0, {reset_cause_flag_o, safe_open_o});
      @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      tick(2);
      // with the clock enable low the signature must not be taken
      @(posedge clk_sys_i);
      clk_en_i <= 1'b0;
      open_safe();
      chk("frozen", 16'h0, {15'h0, safe_open_o});
      @(posedge clk_sys_i);
      clk_en_i <= 1'b1;
      // a stray byte between the two halves must disarm the sequence
      sig(`LPM_SIG_FIRST);
      sig(8'h33);
      sig(`LPM_SIG_SECOND);
      chk("safe_bad", 16'h0, {15'h0, safe_open_o});
      open_safe();
      chk("safe_open", 16'h1, {15'h0, safe_open_o});
      tick(10);
      chk("safe_held", 16'h1, {15'h0, safe_open_o});
      tick(10);
      chk("safe_expired", 16'h0, {15'h0, safe_open_o});
      plan_wr(16'h0000);
      chk("late_write", `LPM_PLAN_RESET, power_planning_reg_o);
      // converter bring-up: prepare, settle 10us (200 cycles), enable
      open_safe();
      plan_wr(16'h409f);
      chk("safe_used", 16'h0, {15'h0, safe_open_o});
      chk("dcdc_pre", 16'h1, {dcdc_on_o, dcdc_bias_o});
      tick(200);
      plan_wr(16'h009f);
      chk("dcdc_locked", 16'h1, {dcdc_on_o, dcdc_bias_o});
      open_safe();
      plan_wr(16'hc09f);
      chk("dcdc_on", 16'h3, {dcdc_on_o, dcdc_bias_o});
      chk("dcdc_run", exp_outs(0, 16'h0), outs());
      open_safe();
      plan_wr(16'h009f);
      chk("dcdc_off", 16'h0, {dcdc_on_o, dcdc_bias_o});
      // idle then halt; halt must take longer since clocks restart first
      enter(1'b0);
      chk("idle_outs", exp_outs(1, 16'h0), outs());
      wake(lat_i, saw_rst, regfirst, clkfirst);
      enter(1'b1);
      chk("halt_outs", exp_outs(2, 16'h0), outs());
      wake(lat_h, saw_rst, regfirst, clkfirst);
      chk("halt_slower", 16'h1, {15'h0, lat_h > lat_i});
      chk("clk_first", 16'h1, {15'h0, clkfirst < lat_h});
      // random retention presets for sleep (core kept) and shutdown
      for (int i = 0; i < 6; i++) begin
         p = $random(seed);
         p[15:14] = 2'b00;
         p[7] = 1'b0;
         p[2] = (i < 3);
         open_safe();
         plan_wr(p);
         chk("preset_run", exp_outs(0, p), outs());
         enter(1'b1);
         chk("low_outs", exp_outs(i < 3 ? 3 : 4, p), outs());
         wake(lat, saw_rst, regfirst, clkfirst);
         if (i < 3) begin
            chk("sleep_slower", 16'h1, {15'h0, lat > lat_h});
            chk("reg_first", 16'h1, {15'h0, regfirst < clkfirst});
            chk("clk_then_core", 16'h1, {15'h0, clkfirst < lat});
            chk("sleep_clk", 16'h1, {15'h0, clocks_on_o});
            chk("sleep_cause", 16'h0, {15'h0, reset_cause_flag_o});
         end else begin
            chk("wake_reset", 16'h1, {15'h0, saw_rst});
            chk("shut_cause", 16'h1, {15'h0, reset_cause_flag_o});
         end
      end
      // second reset clears the sticky cause
      @(posedge clk_sys_i);
      resetn_i <= 1'b0;
      tick(2);
      chk("rerst_cause", 16'h0, {15'h0, reset_cause_flag_o});
      chk("rerst_outs", exp_outs(0, 16'h0), outs());
      chk("rerst_plan", `LPM_PLAN_RESET, power_planning_reg_o);
      @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      tick(2);
      chk("rel_outs", exp_outs(0, 16'h0), outs());
      chk("rel_flags", 16'h0, {reset_cause_flag_o, safe_open_o});
      close_out();
   end
endmodule // test_lpm_seq
